// File: test/boundary_scan_instruction_logic_tb.sv
// Purpose: self-checking bench for the scan instruction controller
// Assumes: link driven by the test host model
// Notes: each instruction except bypass (checked only as the reset value) is loaded then exercised with one data scan
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_instruction_logic_tb import bsi_pkg::*; ;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, o;
  logic dp_tdo = 1'b0;
  logic chip_protected = 1'b0;
  logic startup_done = 1'b0;
  logic [BSI_CHAIN_W-1:0] pin_in = 8'h00;
  logic [BSI_CHAIN_W-1:0] core_out = 8'h00;
  bsi_apply_t apply;
  logic [BSI_IR_W-1:0] instr;
  logic [3:0] cap;
  logic [7:0] dq;
  int fail_count = 0;
  int cmp_count = 0;
  logic oe_seen = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // remembers that the output enable rose in some shift phase
  always @(posedge ref_clk) begin
    if (tdo_oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
  end
  bsi_scan_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .dp_tdo(dp_tdo), .chip_protected(chip_protected),
    .startup_done(startup_done), .pin_in(pin_in), .core_out(core_out), .apply(apply),
    .instr(instr));
  bsi_test_host u_host (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_reset();
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("instr", 8'(instr), 8'(BSI_OP_BYPASS));
    chk("tdo_oe", 8'(tdo_oe), 8'h00);
    u_host.step(1'b0, 1'b0, o);
    $display("test reset done");
  endtask
  task automatic t_extest();
    chip_protected <= 1'b1;
    pin_in <= 8'hA5;
    u_host.ir_scan(BSI_OP_EXTEST, cap);
    chk("ir capture", 8'(cap), 8'h08);
    chk("instr", 8'(instr), 8'(BSI_OP_EXTEST));
    chk("pin drive", 8'(apply.pin_drive_scan), 8'h01);
    u_host.dr_scan(8'h3C, 8, dq);
    chk("pins captured", dq, 8'hA5);
    chk("pin latch", apply.pin_out, 8'h3C);
    chk("tdo_oe shift", 8'(oe_seen), 8'h01);
    $display("test extest done");
  endtask
  task automatic t_sample();
    chip_protected <= 1'b0;
    startup_done <= 1'b1;
    pin_in <= 8'h5A;
    u_host.ir_scan(BSI_OP_SAMPLE, cap);
    chk("ir capture", 8'(cap), 8'h01);
    chk("instr", 8'(instr), 8'(BSI_OP_SAMPLE));
    chk("pin drive", 8'(apply.pin_drive_scan), 8'h00);
    u_host.dr_scan(8'hFF, 8, dq);
    chk("pins captured", dq, 8'h5A);
    chk("pin latch", apply.pin_out, 8'h3C);
    $display("test sample done");
  endtask
  task automatic t_intest();
    core_out <= 8'hC3;
    u_host.ir_scan(BSI_OP_INTEST, cap);
    chk("instr", 8'(instr), 8'(BSI_OP_INTEST));
    u_host.dr_scan(8'h96, 8, dq);
    chk("core captured", dq, 8'hC3);
    chk("core latch", apply.core_in, 8'h96);
    chk("core drive", 8'(apply.core_drive_scan), 8'h01);
    chk("pin latch", apply.pin_out, 8'h3C);
    $display("test intest done");
  endtask
  task automatic t_clamp();
    startup_done <= 1'b0;
    u_host.ir_scan(BSI_OP_CLAMP, cap);
    chk("ir capture intest", 8'(cap), 8'h01);
    chk("instr", 8'(instr), 8'(BSI_OP_CLAMP));
    chk("pin drive", 8'(apply.pin_drive_scan), 8'h01);
    // a one-bit path delays data by one bit behind the captured zero
    u_host.dr_scan(8'h05, 3, dq);
    chk("bypass path", dq, 8'h02);
    $display("test clamp done");
  endtask
  task automatic t_unknown();
    dp_tdo <= 1'b1;
    u_host.ir_scan(4'hE, cap);
    chk("instr", 8'(instr), 8'h0E);
    u_host.dr_scan(8'h00, 2, dq);
    chk("port output", dq, 8'h03);
    chk("tdo_oe idle", 8'(tdo_oe), 8'h00);
    $display("test foreign code done");
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial begin
    t_reset();
    t_extest();
    t_sample();
    t_intest();
    t_clamp();
    t_unknown();
    close_out();
  end
endmodule
`default_nettype wire

// File: test/bsi_test_host.sv
// Purpose: test controller model driving the scan link pins
// Assumes: tck low and high phases of four ref_clk each, 200 ns period
// Notes: tck rests low between frames; tdi toggles outside shift bits
`timescale 1ns/1ps
`default_nettype none
module bsi_test_host (
  // clock
  input wire logic ref_clk,
  // link pins
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tdo lags the tck fall by four cycles, so it is read late in the high phase
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    o = tdo;
    tck <= 1'b0;
  endtask
  task automatic ir_scan(input logic [3:0] code, output logic [3:0] cap);
    logic o;
    step(1'b1, ~tdi, o);
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < 4; i++) begin
      step(i == 3, code[i], o);
      cap[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  task automatic dr_scan(input logic [7:0] din, input int n, output logic [7:0] cap);
    logic o;
    cap = 8'h00;
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      cap[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule
`default_nettype wire

// File: verilog/bsi_pkg.sv
// Purpose: shared constants and types for the boundary-scan instruction logic
// Assumes: 4-bit instruction register, tap sampled on ref_clk
// Notes: chain length is a package constant with a plain default
package bsi_pkg;
  localparam int BSI_IR_W = 4;
  localparam int BSI_CHAIN_W = 8;
  localparam logic [3:0] BSI_OP_EXTEST = 4'h0;
  localparam logic [3:0] BSI_OP_SAMPLE = 4'h1;
  localparam logic [3:0] BSI_OP_INTEST = 4'h4;
  localparam logic [3:0] BSI_OP_CLAMP = 4'h5;
  localparam logic [3:0] BSI_OP_BYPASS = 4'hF;
  localparam logic [1:0] BSI_CAP_MID = 2'h0;
  localparam logic BSI_CAP_INTEST_LSB = 1'h1;
  localparam logic BSI_BYPASS_CAP = 1'h0;

  typedef enum logic [3:0] {
    BSI_RESET = 4'h0, BSI_IDLE = 4'h1, BSI_SEL_DR = 4'h2, BSI_CAP_DR = 4'h3,
    BSI_SH_DR = 4'h4, BSI_EX1_DR = 4'h5, BSI_PAU_DR = 4'h6, BSI_EX2_DR = 4'h7,
    BSI_UPD_DR = 4'h8, BSI_SEL_IR = 4'h9, BSI_CAP_IR = 4'hA, BSI_SH_IR = 4'hB,
    BSI_EX1_IR = 4'hC, BSI_PAU_IR = 4'hD, BSI_EX2_IR = 4'hE, BSI_UPD_IR = 4'hF
  } bsi_state_t;

  typedef struct packed {
    logic [BSI_CHAIN_W-1:0] pin_out;
    logic pin_drive_scan;
    logic [BSI_CHAIN_W-1:0] core_in;
    logic core_drive_scan;
  } bsi_apply_t;
endpackage

// File: verilog/bsi_scan_ctrl.sv
// Purpose: boundary-scan test controller with instruction and data register handling
// Assumes: test clock, mode select and data input arrive from pins and are resynchronised
// Notes: link pins sampled by ref_clk; test clock must stay below a quarter of ref_clk
`timescale 1ns/1ps
`default_nettype none
module bsi_scan_ctrl
  import bsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // test link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // debug port serial output
  input wire logic dp_tdo,
  // device status
  input wire logic chip_protected,
  input wire logic startup_done,
  // pins and core
  input wire logic [BSI_CHAIN_W-1:0] pin_in,
  input wire logic [BSI_CHAIN_W-1:0] core_out,
  output bsi_apply_t apply,
  output logic [BSI_IR_W-1:0] instr
);
  logic [2:0] tck_s, tms_s, tdi_s;
  // pin levels come from outside the clock domain, so capture reads a two-flop copy
  logic [BSI_CHAIN_W-1:0] pin_s1, pin_s2;
  logic tck_rise, tck_fall;
  bsi_state_t state, next_state;
  logic [BSI_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
  logic [BSI_CHAIN_W-1:0] bs_sh, next_bs_sh, pin_lat, next_pin_lat, core_lat, next_core_lat;
  logic bypass, next_bypass, tdo_r, next_tdo_r, oe_r, next_oe_r;

  // only bit 2 is read by logic; bits 0 and 1 are plain synchroniser stages
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_s <= 3'h0;
      tms_s <= 3'h7;
      tdi_s <= 3'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[1:0], tms};
      tdi_s <= {tdi_s[1:0], tdi};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end
  // compare stage 2 to a fourth flop so stages 0 and 1 feed nothing but the next stage
  logic tck_d;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_d <= 1'h0;
    end else begin
      tck_d <= tck_s[2];
    end
  end
  assign tck_rise = tck_s[2] & ~tck_d;
  assign tck_fall = ~tck_s[2] & tck_d;

  function automatic logic is_bscan(input logic [BSI_IR_W-1:0] op);
    is_bscan = (op == BSI_OP_EXTEST) || (op == BSI_OP_SAMPLE) ||
               (op == BSI_OP_INTEST) || (op == BSI_OP_CLAMP);
  endfunction
  function automatic logic uses_chain(input logic [BSI_IR_W-1:0] op);
    uses_chain = (op == BSI_OP_EXTEST) || (op == BSI_OP_SAMPLE) || (op == BSI_OP_INTEST);
  endfunction

  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state)
        BSI_RESET: next_state = tms_s[2] ? BSI_RESET : BSI_IDLE;
        BSI_IDLE: next_state = tms_s[2] ? BSI_SEL_DR : BSI_IDLE;
        BSI_SEL_DR: next_state = tms_s[2] ? BSI_SEL_IR : BSI_CAP_DR;
        BSI_CAP_DR: next_state = tms_s[2] ? BSI_EX1_DR : BSI_SH_DR;
        BSI_SH_DR: next_state = tms_s[2] ? BSI_EX1_DR : BSI_SH_DR;
        BSI_EX1_DR: next_state = tms_s[2] ? BSI_UPD_DR : BSI_PAU_DR;
        BSI_PAU_DR: next_state = tms_s[2] ? BSI_EX2_DR : BSI_PAU_DR;
        BSI_EX2_DR: next_state = tms_s[2] ? BSI_UPD_DR : BSI_SH_DR;
        BSI_UPD_DR: next_state = tms_s[2] ? BSI_SEL_DR : BSI_IDLE;
        BSI_SEL_IR: next_state = tms_s[2] ? BSI_RESET : BSI_CAP_IR;
        BSI_CAP_IR: next_state = tms_s[2] ? BSI_EX1_IR : BSI_SH_IR;
        BSI_SH_IR: next_state = tms_s[2] ? BSI_EX1_IR : BSI_SH_IR;
        BSI_EX1_IR: next_state = tms_s[2] ? BSI_UPD_IR : BSI_PAU_IR;
        BSI_PAU_IR: next_state = tms_s[2] ? BSI_EX2_IR : BSI_PAU_IR;
        BSI_EX2_IR: next_state = tms_s[2] ? BSI_UPD_IR : BSI_SH_IR;
        BSI_UPD_IR: next_state = tms_s[2] ? BSI_SEL_DR : BSI_IDLE;
        default: next_state = BSI_RESET;
      endcase
    end
  end

  always_comb begin
    next_ir_sh = ir_sh;
    next_bs_sh = bs_sh;
    next_bypass = bypass;
    next_ir = ir;
    next_pin_lat = pin_lat;
    next_core_lat = core_lat;
    next_tdo_r = tdo_r;
    next_oe_r = oe_r;
    if (tck_rise) begin
      if (state == BSI_CAP_IR) begin
        next_ir_sh = {chip_protected, BSI_CAP_MID,
                      (ir == BSI_OP_INTEST) ? BSI_CAP_INTEST_LSB : startup_done};
      end else if (state == BSI_SH_IR) begin
        next_ir_sh = {tdi_s[2], ir_sh[BSI_IR_W-1:1]};
      end
      if (state == BSI_CAP_DR) begin
        if (ir == BSI_OP_INTEST) begin
          next_bs_sh = core_out;
        end else if (uses_chain(ir)) begin
          next_bs_sh = pin_s2;
        end
        next_bypass = BSI_BYPASS_CAP;
      end else if (state == BSI_SH_DR) begin
        if (uses_chain(ir)) begin
          next_bs_sh = {tdi_s[2], bs_sh[BSI_CHAIN_W-1:1]};
        end
        next_bypass = tdi_s[2];
      end
    end
    if (tck_fall) begin
      if (state == BSI_RESET) begin
        next_ir = BSI_OP_BYPASS;
      end else if (state == BSI_UPD_IR) begin
        next_ir = ir_sh;
      end
      // sample/preload never reaches the latches, so shifting leaves pins alone
      if (state == BSI_UPD_DR && ir == BSI_OP_EXTEST) begin
        next_pin_lat = bs_sh;
      end
      if (state == BSI_UPD_DR && ir == BSI_OP_INTEST) begin
        next_core_lat = bs_sh;
      end
      next_oe_r = (state == BSI_SH_DR) || (state == BSI_SH_IR);
      if (state == BSI_SH_IR) begin
        next_tdo_r = ir_sh[0];
      end else if (!is_bscan(ir)) begin
        next_tdo_r = dp_tdo;
      end else if (ir == BSI_OP_CLAMP) begin
        next_tdo_r = bypass;
      end else begin
        next_tdo_r = bs_sh[0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= BSI_RESET;
      ir_sh <= 4'h0;
      ir <= BSI_OP_BYPASS;
      bs_sh <= '0;
      bypass <= 1'h0;
      pin_lat <= '0;
      core_lat <= '0;
      tdo_r <= 1'h0;
      oe_r <= 1'h0;
    end else begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      bs_sh <= next_bs_sh;
      bypass <= next_bypass;
      pin_lat <= next_pin_lat;
      core_lat <= next_core_lat;
      tdo_r <= next_tdo_r;
      oe_r <= next_oe_r;
    end
  end

  // pins follow the latches from the instant the update loads these opcodes
  always_comb begin
    apply.pin_out = pin_lat;
    apply.pin_drive_scan = (ir == BSI_OP_EXTEST) || (ir == BSI_OP_CLAMP) ||
                           (ir == BSI_OP_INTEST);
    apply.core_in = core_lat;
    apply.core_drive_scan = (ir == BSI_OP_INTEST);
  end
  assign tdo = tdo_r;
  assign tdo_oe = oe_r;
  assign instr = ir;

  // assertions and covers
  property p_cap_ir;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_CAP_IR) |=> ir_sh[2:1] == BSI_CAP_MID;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir mid bits wrong");
  property p_cap_intest;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_CAP_IR && ir == BSI_OP_INTEST) |=> ir_sh[0];
  endproperty
  a_cap_intest: assert property (p_cap_intest) else $error("intest lsb not one");
  property p_p_bit;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_CAP_IR) |=> ir_sh[3] == $past(chip_protected);
  endproperty
  a_p_bit: assert property (p_p_bit) else $error("p bit wrong");
  property p_ir_shift;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_SH_IR) |=> ir_sh[2:0] == $past(ir_sh[3:1]);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("ir shift wrong");
  property p_dr_shift;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_SH_DR && uses_chain(ir)) |=>
      bs_sh[BSI_CHAIN_W-2:0] == $past(bs_sh[BSI_CHAIN_W-1:1]);
  endproperty
  a_dr_shift: assert property (p_dr_shift) else $error("chain shift wrong");
  property p_preload;
    @(posedge ref_clk) disable iff (sys_rst)
      (ir == BSI_OP_SAMPLE) |=> $stable(pin_lat) || $past(ir) != BSI_OP_SAMPLE;
  endproperty
  a_preload: assert property (p_preload) else $error("preload touched latch");
  property p_extest_upd;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_fall && state == BSI_UPD_DR && ir == BSI_OP_EXTEST) |=> pin_lat == $past(bs_sh);
  endproperty
  a_extest_upd: assert property (p_extest_upd) else $error("update-dr missed");
  property p_clamp_cap;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_rise && state == BSI_CAP_DR) |=> bypass == BSI_BYPASS_CAP;
  endproperty
  a_clamp_cap: assert property (p_clamp_cap) else $error("bypass not zero");
  property p_drive;
    @(posedge ref_clk) disable iff (sys_rst)
      (ir == BSI_OP_CLAMP || ir == BSI_OP_EXTEST) |-> apply.pin_drive_scan;
  endproperty
  a_drive: assert property (p_drive) else $error("pins not driven");
  property p_dp_route;
    @(posedge ref_clk) disable iff (sys_rst)
      (tck_fall && state != BSI_SH_IR && !is_bscan(ir)) |=> tdo == $past(dp_tdo);
  endproperty
  a_dp_route: assert property (p_dp_route) else $error("tdo not from debug port");
  c_upd_ir: cover property (@(posedge ref_clk) tck_fall && state == BSI_UPD_IR);
  c_extest: cover property (@(posedge ref_clk) tck_fall && state == BSI_UPD_DR
                            && ir == BSI_OP_EXTEST);
  c_clamp: cover property (@(posedge ref_clk) ir == BSI_OP_CLAMP && state == BSI_SH_DR);
endmodule
`default_nettype wire
